// ### rtl/bpu_top.sv
// Branch prediction unit: static predictor, return stack and target buffer.
`timescale 1ns/1ps
module bpu_top #(
    parameter int ENTRIES = bpu_pkg::BTB_ENTRIES,
    parameter int DEPTH = bpu_pkg::RAS_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Decode request and resolution report
    input wire bpu_pkg::bpu_req_t req_i,
    input wire bpu_pkg::bpu_res_t res_i,
    // Prediction to fetch
    output bpu_pkg::bpu_pred_t pred_o
);

    localparam int IW = $clog2(ENTRIES);
    localparam int SW = $clog2(DEPTH);
    localparam int AW = bpu_pkg::ADDR_W;
    localparam int TW = AW - IW - 2;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [ENTRIES-1:0] btb_valid_r;
    logic [TW-1:0] btb_tag_r [ENTRIES];
    logic [AW-1:0] btb_tgt_r [ENTRIES];
    logic [AW-1:0] ras_r [DEPTH];
    logic [SW-1:0] ras_top_r;
    logic [SW:0] ras_cnt_r;
    logic stop_r;
    bpu_pkg::bpu_pred_t pred_r;
    bpu_pkg::bpu_pred_t pred_nxt;

    // ------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------
    // The buffer is direct-mapped on word addresses; two branches that share
    // an index evict each other, which costs a misprediction and nothing more.
    logic [IW-1:0] lk_idx;
    logic [TW-1:0] lk_tag;
    logic [IW-1:0] up_idx;
    logic [TW-1:0] up_tag;
    logic hit;
    logic ras_push;
    logic ras_pop;
    logic ras_have;
    logic [SW-1:0] ras_rd;

    assign lk_idx = req_i.pc[IW+1:2];
    assign lk_tag = req_i.pc[AW-1:IW+2];
    assign up_idx = res_i.pc[IW+1:2];
    assign up_tag = res_i.pc[AW-1:IW+2];
    assign hit = btb_valid_r[lk_idx] && (btb_tag_r[lk_idx] == lk_tag);
    assign ras_have = (ras_cnt_r != '0);
    // The top pointer names the next free slot, so the newest address sits one
    // below it; the pointer wraps, so after an overflow the newest ones remain.
    assign ras_rd = ras_top_r - {{(SW-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // Prediction
    // ------------------------------------------------------------
    always_comb begin
        pred_nxt = '0;
        ras_push = 1'b0;
        ras_pop = 1'b0;
        // A misprediction outranks the request of the same cycle: that request
        // lies on the wrong path and must not touch the return stack.
        if (res_i.valid && res_i.mispredict) begin
            pred_nxt.valid = 1'b1;
            pred_nxt.redirect = 1'b1;
            pred_nxt.taken = res_i.taken;
            pred_nxt.next_pc = res_i.taken ? res_i.target : res_i.seq_pc;
        end else if (req_i.valid && !stop_r) begin
            pred_nxt.valid = 1'b1;
            pred_nxt.next_pc = req_i.seq_pc;
            unique case (req_i.kind)
                bpu_pkg::BPU_NONE: begin
                end
                bpu_pkg::BPU_COND: begin
                    if (hit) begin
                        pred_nxt.taken = 1'b1;
                        pred_nxt.next_pc = btb_tgt_r[lk_idx];
                    // A branch to itself is a tight loop, so equal counts as backward.
                    end else if (req_i.target <= req_i.pc) begin
                        pred_nxt.taken = 1'b1;
                        pred_nxt.next_pc = req_i.target;
                    end
                end
                bpu_pkg::BPU_JUMP: begin
                    pred_nxt.taken = 1'b1;
                    pred_nxt.next_pc = req_i.target;
                end
                bpu_pkg::BPU_CALL: begin
                    pred_nxt.taken = 1'b1;
                    pred_nxt.next_pc = hit ? btb_tgt_r[lk_idx] : req_i.target;
                    ras_push = 1'b1;
                end
                bpu_pkg::BPU_RET: begin
                    if (ras_have) begin
                        pred_nxt.taken = 1'b1;
                        pred_nxt.next_pc = ras_r[ras_rd];
                        ras_pop = 1'b1;
                    end
                end
                bpu_pkg::BPU_IND, bpu_pkg::BPU_ICALL: begin
                    if (hit) begin
                        pred_nxt.taken = 1'b1;
                        pred_nxt.next_pc = btb_tgt_r[lk_idx];
                    end
                    // An indirect call still pushes, so its return stays paired.
                    ras_push = (req_i.kind == bpu_pkg::BPU_ICALL);
                end
                bpu_pkg::BPU_STOP: begin
                    pred_nxt.stop = 1'b1;
                end
            endcase
            pred_nxt.redirect = pred_nxt.taken;
        end
    end

    // While ce_i is low every register holds, so fetch keeps the last answer.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pred_r <= '0;
        end else if (ce_i) begin
            pred_r <= pred_nxt;
        end
    end

    // Decode stays halted until a redirect restarts fetch elsewhere.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_r <= 1'b0;
        end else if (ce_i) begin
            if (res_i.valid && res_i.mispredict) begin
                stop_r <= 1'b0;
            end else if (pred_nxt.stop) begin
                stop_r <= 1'b1;
            end else if (pred_nxt.redirect) begin
                stop_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------
    // A circular buffer: overflow silently overwrites the oldest entry, and
    // the branch unit repairs any return that then mispredicts.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ras_top_r <= '0;
            ras_cnt_r <= '0;
        end else if (ce_i) begin
            if (ras_push) begin
                ras_top_r <= ras_top_r + {{(SW-1){1'b0}}, 1'b1};
                // The count saturates so that pops after an overflow stop at an
                // empty stack instead of wrapping into overwritten entries.
                if (ras_cnt_r != (SW+1)'(DEPTH)) begin
                    ras_cnt_r <= ras_cnt_r + {{SW{1'b0}}, 1'b1};
                end
            end else if (ras_pop) begin
                ras_top_r <= ras_rd;
                ras_cnt_r <= ras_cnt_r - {{SW{1'b0}}, 1'b1};
            end
        end
    end

    generate
        for (genvar g = 0; g < DEPTH; g++) begin : g_ras
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    ras_r[g] <= bpu_pkg::ADDR_RESET;
                end else if (ce_i && ras_push && (ras_top_r == SW'(g))) begin
                    ras_r[g] <= req_i.seq_pc;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Target buffer
    // ------------------------------------------------------------
    generate
        for (genvar e = 0; e < ENTRIES; e++) begin : g_btb
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    btb_valid_r[e] <= 1'b0;
                    btb_tag_r[e] <= '0;
                    btb_tgt_r[e] <= bpu_pkg::ADDR_RESET;
                end else if (ce_i && res_i.valid && (up_idx == IW'(e))) begin
                    if (res_i.taken) begin
                        btb_valid_r[e] <= 1'b1;
                        btb_tag_r[e] <= up_tag;
                        btb_tgt_r[e] <= res_i.target;
                    // Only a matching entry is cleared; a neighbour on the index stays.
                    end else if (res_i.mispredict && btb_tag_r[e] == up_tag) begin
                        btb_valid_r[e] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output
    // ------------------------------------------------------------
    // Fetch sees the flop directly, with no logic after the register.
    assign pred_o = pred_r;

endmodule : bpu_top

// ### rtl/bpu_pkg.sv
// Package with shared types and constants of the branch prediction unit.
package bpu_pkg;

    localparam int ADDR_W = 32;
    localparam int RAS_DEPTH = 16;
    localparam int BTB_ENTRIES = 64;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;

    // Branch classes as seen by decode.
    typedef enum logic [2:0] {
        BPU_NONE = 3'h0,
        BPU_COND = 3'h1,
        BPU_JUMP = 3'h2,
        BPU_CALL = 3'h3,
        BPU_RET = 3'h4,
        BPU_IND = 3'h5,
        BPU_ICALL = 3'h6,
        BPU_STOP = 3'h7
    } bpu_kind_t;

    // Request from decode for one instruction.
    typedef struct packed {
        logic valid;
        bpu_kind_t kind;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] seq_pc;
        logic [ADDR_W-1:0] target;
    } bpu_req_t;

    // Resolution report from the branch unit.
    typedef struct packed {
        logic valid;
        logic mispredict;
        logic taken;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] seq_pc;
    } bpu_res_t;

    // Prediction answer to fetch.
    typedef struct packed {
        logic valid;
        logic taken;
        logic redirect;
        logic stop;
        logic [ADDR_W-1:0] next_pc;
    } bpu_pred_t;

endpackage : bpu_pkg

// ### verif/bpu_properties.sv
// Checker of the prediction rules at the unit's ports.
`timescale 1ns/1ps
module bpu_properties #(parameter int ENTRIES = 64, parameter int DEPTH = 16) (
    // Unit ports
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire bpu_pkg::bpu_req_t req_i,
    input wire bpu_pkg::bpu_res_t res_i,
    input wire bpu_pkg::bpu_pred_t pred_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Static cases are judged only before any resolution can fill the buffer.
    logic stop_r, fresh_r;
    bpu_pkg::bpu_kind_t k;
    wire mis = ce_i && res_i.valid && res_i.mispredict;
    wire take = ce_i && req_i.valid && !stop_r && !mis;
    wire clean = take && fresh_r && !res_i.valid;
    wire tk = pred_o.taken;
    wire [31:0] nx = pred_o.next_pc;
    assign k = req_i.kind;
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i) stop_r <= 1'b0;
        else if (mis || take && k == bpu_pkg::BPU_STOP) stop_r <= !mis;
    always_ff @(posedge mclk_i or negedge rst_n_i)
        if (!rst_n_i) fresh_r <= 1'b1;
        else if (ce_i && res_i.valid) fresh_r <= 1'b0;
    a_fwd_fall_thru: assert property (clean && k == bpu_pkg::BPU_COND &&
        req_i.target > req_i.pc |=> pred_o.valid && !tk && nx == $past(req_i.seq_pc))
        else $error("forward branch");
    a_back_taken: assert property (clean && k == bpu_pkg::BPU_COND &&
        req_i.target <= req_i.pc |=> tk && nx == $past(req_i.target)) else $error("back");
    a_call_taken: assert property (clean && k == bpu_pkg::BPU_CALL |=>
        tk && nx == $past(req_i.target)) else $error("call");
    a_ind_fall_thru: assert property (clean &&
        (k == bpu_pkg::BPU_IND || k == bpu_pkg::BPU_ICALL) |=> !tk && nx == $past(req_i.seq_pc))
        else $error("indirect");
    a_stop_marks: assert property (take && k == bpu_pkg::BPU_STOP |=>
        pred_o.stop && nx == $past(req_i.seq_pc)) else $error("stop");
    a_stop_refuse: assert property (stop_r && ce_i && req_i.valid && !res_i.valid |=>
        !pred_o.valid) else $error("refuse");
    a_ret_pops: assert property (take && k == bpu_pkg::BPU_CALL ##1 take &&
        !res_i.valid && k == bpu_pkg::BPU_RET |=> tk && nx == $past(req_i.seq_pc, 2))
        else $error("return");
    a_misp_redirect: assert property (mis && res_i.taken |=>
        pred_o.valid && pred_o.redirect && nx == $past(res_i.target)) else $error("redirect");
    c_pair: cover property (take && k == bpu_pkg::BPU_CALL ##1 take && k == bpu_pkg::BPU_RET);
    c_refuse: cover property (stop_r && req_i.valid);
    c_misp: cover property (mis);
endmodule : bpu_properties
bind bpu_top bpu_properties #(.ENTRIES(ENTRIES), .DEPTH(DEPTH)) u_props (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req_i), .res_i(res_i), .pred_o(pred_o));

// ### verif/bpu_fe_model.sv
// Decode and resolution stages as the unit sees them.
`timescale 1ns/1ps
module bpu_fe_model (
    input wire logic mclk_i,
    // Toward the unit
    output bpu_pkg::bpu_req_t req_o = '0,
    output bpu_pkg::bpu_res_t res_o = '0
);
    // Released fields flip so a stale value can never pass for fresh data.
    task automatic drop();
        @(posedge mclk_i);
        req_o <= {1'b0, ~req_o[$bits(req_o)-2:0]};
        res_o <= {1'b0, ~res_o[$bits(res_o)-2:0]};
    endtask : drop
    task automatic send(input bpu_pkg::bpu_kind_t k, input logic [31:0] pc, tg, input bit last);
        @(posedge mclk_i);
        req_o <= {1'b1, k, pc, pc + 32'h4, tg};
        if (last) drop();
    endtask : send
    task automatic resolve(input logic m, tk, input logic [31:0] pc, tg);
        @(posedge mclk_i);
        res_o <= {1'b1, m, tk, pc, tg, pc + 32'h4};
        drop();
    endtask : resolve
endmodule : bpu_fe_model

// ### verif/bpu_top_tb.sv
// Self-checking testbench of the branch prediction unit.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module bpu_top_tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b0;
    int err_count = 0;
    int checks_done = 0;
    bpu_pkg::bpu_req_t req;
    bpu_pkg::bpu_res_t res;
    bpu_pkg::bpu_pred_t pred;
    always #4 mclk_i = ~mclk_i;
    bpu_fe_model fe (.mclk_i(mclk_i), .req_o(req), .res_o(res));
    bpu_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .req_i(req), .res_i(res),
        .pred_o(pred));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic chk(input bpu_pkg::bpu_kind_t k, input logic [31:0] pc, tg, input logic tk,
        input logic [31:0] nx);
        fe.send(k, pc, tg, 1'b1);
        #1;
        `CHK({pred.valid, pred.taken, pred.redirect, pred.stop, pred.next_pc},
            {1'b1, tk, tk, k == bpu_pkg::BPU_STOP, nx})
    endtask : chk
    task automatic t_static();
        chk(bpu_pkg::BPU_COND, 32'h100, 32'h140, 1'b0, 32'h104);
        chk(bpu_pkg::BPU_COND, 32'h200, 32'h200, 1'b1, 32'h200);
        chk(bpu_pkg::BPU_CALL, 32'h300, 32'h800, 1'b1, 32'h800);
        chk(bpu_pkg::BPU_IND, 32'h400, 32'h0, 1'b0, 32'h404);
        chk(bpu_pkg::BPU_ICALL, 32'h500, 32'h0, 1'b0, 32'h504);
    endtask : t_static
    // Seventeen calls overflow the stack, so the last return finds it empty.
    task automatic t_stack();
        fe.send(bpu_pkg::BPU_CALL, 32'h1000, 32'h3000, 1'b0);
        chk(bpu_pkg::BPU_RET, 32'h3000, 32'h0, 1'b1, 32'h1004);
        for (int i = 1; i <= 17; i++) begin
            chk(bpu_pkg::BPU_CALL, 32'(16 * i), 32'h800, 1'b1, 32'h800);
        end
        for (int i = 17; i > 1; i--) begin
            chk(bpu_pkg::BPU_RET, 32'h900, 32'h0, 1'b1, 32'(16 * i + 4));
        end
        chk(bpu_pkg::BPU_RET, 32'h900, 32'h0, 1'b0, 32'h904);
    endtask : t_stack
    task automatic t_stop();
        chk(bpu_pkg::BPU_STOP, 32'h700, 32'h0, 1'b0, 32'h704);
        fe.send(bpu_pkg::BPU_JUMP, 32'h704, 32'hB00, 1'b1);
        #1;
        `CHK(pred.valid, 1'b0)
        fe.resolve(1'b1, 1'b1, 32'h400, 32'hC00);
        #1;
        `CHK({pred.valid, pred.redirect, pred.next_pc}, {2'b11, 32'hC00})
        chk(bpu_pkg::BPU_IND, 32'h400, 32'h0, 1'b1, 32'hC00);
        fe.resolve(1'b0, 1'b1, 32'h400, 32'hD00);
        chk(bpu_pkg::BPU_IND, 32'h400, 32'h0, 1'b1, 32'hD00);
        fe.resolve(1'b1, 1'b0, 32'h400, 32'hD00);
        #1;
        `CHK({pred.valid, pred.redirect, pred.taken, pred.next_pc}, {3'b110, 32'h404})
        chk(bpu_pkg::BPU_IND, 32'h400, 32'h0, 1'b0, 32'h404);
        fe.resolve(1'b0, 1'b0, 32'h120, 32'h160);
        chk(bpu_pkg::BPU_COND, 32'h120, 32'h160, 1'b0, 32'h124);
    endtask : t_stop
    // A frozen unit keeps its last answer and lets offered requests pass by.
    task automatic t_freeze();
        fe.send(bpu_pkg::BPU_COND, 32'h680, 32'h600, 1'b0);
        @(posedge mclk_i);
        ce_i <= 1'b0;
        fe.send(bpu_pkg::BPU_NONE, 32'h690, 32'h0, 1'b1);
        #1;
        `CHK({pred.valid, pred.taken, pred.next_pc}, {2'b11, 32'h600})
        @(posedge mclk_i);
        ce_i <= 1'b1;
        chk(bpu_pkg::BPU_NONE, 32'h6A0, 32'h0, 1'b0, 32'h6A4);
    endtask : t_freeze
    // A reset in mid-run empties the return stack and the target buffer.
    task automatic t_reset();
        fe.resolve(1'b0, 1'b1, 32'h440, 32'hE00);
        fe.send(bpu_pkg::BPU_CALL, 32'h1000, 32'h3000, 1'b1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        chk(bpu_pkg::BPU_RET, 32'h3000, 32'h0, 1'b0, 32'h3004);
        chk(bpu_pkg::BPU_IND, 32'h440, 32'h0, 1'b0, 32'h444);
    endtask : t_reset
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        ce_i <= 1'b1;
        t_static();
        t_freeze();
        t_stack();
        t_stop();
        t_reset();
        final_report();
    end
    initial begin
        repeat (2000) @(posedge mclk_i);
        err_count++;
        final_report();
    end
endmodule : bpu_top_tb
